// ---- include/aipmc_pkg.sv ----
`default_nettype none
package aipmc_pkg;
  // register addresses on the control port
  localparam logic [3:0] ADDR_CTRL2 = 4'h1;
  localparam logic [3:0] ADDR_AICFG = 4'h2;
  localparam logic [3:0] ADDR_PEAK_L = 4'h3;
  localparam logic [3:0] ADDR_PEAK_R = 4'h4;
  // analog input configuration field positions
  localparam int CFG_RIGHT_SEL = 0;
  localparam int CFG_RIGHT_BUF_OFF = 1;
  localparam int CFG_LEFT_SEL = 2;
  localparam int CFG_LEFT_BUF_OFF = 3;
  localparam int CFG_RIGHT_SE = 4;
  localparam int CFG_LEFT_SE = 5;
  localparam int CFG_DIV_LO = 6;
  localparam int CFG_DIV_HI = 7;
  localparam logic [7:0] CFG_RESET = 8'h00;
  // second control register field positions (subset held here)
  localparam int CTRL2_ROLE = 2;
  localparam int CTRL2_FMT_LO = 5;
  localparam int CTRL2_FMT_HI = 6;
  localparam int CTRL2_MOD_EN = 7;
  localparam logic [7:0] CTRL2_RESET = 8'h00;
  localparam logic [7:0] CTRL2_WMASK = 8'hE4;
  // readback word layout
  localparam int PEAK_W = 6;
  localparam logic [1:0] PEAK_TAG = 2'h2;
  localparam logic [1:0] CFG_TAG = 2'h0;
  localparam logic [PEAK_W-1:0] PEAK_RESET = 6'h00;
  // strap vector positions
  localparam int STRAP_EXT = 0;
  localparam int STRAP_ROLE = 1;
  localparam int STRAP_RATIO = 2;
  localparam int STRAP_FMT_LO = 3;
  localparam int STRAP_FMT_HI = 4;
  localparam int STRAP_N = 5;
  localparam logic [4:0] STRAP_RESET = 5'h00;
  typedef enum logic [1:0] {
    AIPMC_DIV_BY1 = 2'b00,
    AIPMC_DIV_BY2 = 2'b01,
    AIPMC_DIV_BY3 = 2'b10,
    AIPMC_DIV_BY1B = 2'b11
  } aipmc_div_t;
  typedef enum logic [1:0] {
    AIPMC_FMT_I2S = 2'b00,
    AIPMC_FMT_RJ = 2'b01,
    AIPMC_FMT_DSP = 2'b10,
    AIPMC_FMT_LJ = 2'b11
  } aipmc_fmt_t;
  typedef enum logic [1:0] {
    AIPMC_MOD_IDLE = 2'b00,
    AIPMC_MOD_LEFT = 2'b01,
    AIPMC_MOD_RIGHT = 2'b10
  } aipmc_mod_t;
  // divider terminal counts for /1, /2 and /3
  localparam logic [1:0] DIV_LAST_BY1 = 2'h0;
  localparam logic [1:0] DIV_LAST_BY2 = 2'h1;
  localparam logic [1:0] DIV_LAST_BY3 = 2'h2;
endpackage : aipmc_pkg
`default_nettype wire

// ---- hw/aipmc_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none
// Function
// R01: buffer-disable bit powers down channel input buffer
// R02: buffer-disable bits reset to zero
// R03: input-select picks positive or negative pin
// R04: input-select only counts when single-ended enabled
// R05: single-ended enable converts selected input
// R06: internal clock is 256 times sample rate
// R07: divider code gives /1, /2, /3, /1
// R08: left peak read-only at address 0011b
// R09: right peak read-only at address 0100b
// R10: peak code in six low readback bits
// R11: peak tracking only while peak enable set
// R12: code zero full scale, ones -63 dBFS
// R13: peak register holds highest level seen
// R14: reading a peak register clears it
// R15: strap pin hands settings to strap pins
// R16: role strap low drives frame clocks
// R17: ratio strap selects 256 or 512
// R18: format straps act like format field
// R19: other functions stay at power-on defaults
// R20: modulator mode drives data and sampling clock
// R21: left data low phase, right high
// R22: format codes I2S, RJ, DSP, LJ
// R23: reset default is master role
// R24: replace stored peak only with smaller code
module aipmc_ctrl #(
  parameter int MOD_BITS = 4
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [3:0] regAddr,
  input wire logic [9:0] regWrData,
  output logic rdValid,
  output logic [15:0] rdData,
  input wire logic peakTrackEnable,
  input wire logic ctrlRatio512,
  input wire logic convValid,
  input wire logic [aipmc_pkg::PEAK_W-1:0] convLeftCode,
  input wire logic [aipmc_pkg::PEAK_W-1:0] convRightCode,
  input wire logic strapControlEnable,
  input wire logic strapRole,
  input wire logic strapRatio,
  input wire logic [1:0] strapFormat,
  input wire logic modInValid,
  output logic modInReady,
  input wire logic [2*MOD_BITS-1:0] modInData,
  output logic imclkEnable,
  output logic leftBufferPowerDown,
  output logic rightBufferPowerDown,
  output logic leftSingleEnded,
  output logic rightSingleEnded,
  output logic leftSelectNeg,
  output logic rightSelectNeg,
  output logic frameClocksDrive,
  output logic [1:0] dataFormat,
  output logic mclkRatio512,
  output logic modPinsDrive,
  output logic modulatorSampleClock,
  output logic [MOD_BITS-1:0] modData
);

  typedef struct packed {
    logic [aipmc_pkg::STRAP_N-1:0] strapMeta;
    logic [aipmc_pkg::STRAP_N-1:0] strapSync;
    logic [7:0] cfg;
    logic [7:0] ctrl2;
    logic [1:0] divCnt;
    logic imclkEn;
    logic [aipmc_pkg::PEAK_W-1:0] peakL;
    logic [aipmc_pkg::PEAK_W-1:0] peakR;
    logic freshL;
    logic freshR;
    logic rdValid;
    logic [15:0] rdData;
    aipmc_pkg::aipmc_mod_t modState;
    logic [2*MOD_BITS-1:0] modPair;
    logic [MOD_BITS-1:0] modData;
    logic [1:0][2*MOD_BITS-1:0] bufMem;
    logic bufWrPtr;
    logic bufRdPtr;
    logic [1:0] bufCount;
  } aipmc_state_t;

  aipmc_state_t q;
  aipmc_state_t d;

  logic extCtl;
  logic [7:0] cfgEff;
  logic modEn;
  logic peakEn;
  logic bufPush;
  logic bufPop;
  logic [1:0] divLast;
  logic [2*MOD_BITS-1:0] bufHead;

  // the pair word and pin count only fit a width the buffer can serve
  if (MOD_BITS < 1 || MOD_BITS > 8) begin : g_bad_width
    $error("MOD_BITS must lie between 1 and 8");
  end

  // one peak channel: a sample landing on the read cycle wins over the clear
  function automatic logic [aipmc_pkg::PEAK_W:0] peakNext(
    input logic [aipmc_pkg::PEAK_W-1:0] cur,
    input logic fresh,
    input logic rd,
    input logic take,
    input logic [aipmc_pkg::PEAK_W-1:0] code
  );
    logic [aipmc_pkg::PEAK_W:0] r;
    r = {fresh, cur};
    if (take && (fresh || rd || code < cur)) begin // see R13 // see R24
      r = {1'b0, code};
    end else if (rd) begin
      r = {1'b1, aipmc_pkg::PEAK_RESET}; // see R14
    end
    return r;
  endfunction : peakNext

  // strap mode overrides; everything else falls back to power-on values
  always_comb begin
    extCtl = q.strapSync[aipmc_pkg::STRAP_EXT]; // see R15
    cfgEff = extCtl ? aipmc_pkg::CFG_RESET : q.cfg; // see R19
    modEn = !extCtl && q.ctrl2[aipmc_pkg::CTRL2_MOD_EN]; // see R19
    peakEn = !extCtl && peakTrackEnable; // see R11 // see R19
  end

  // divider terminal count from the divider field
  always_comb begin
    case (aipmc_pkg::aipmc_div_t'(cfgEff[aipmc_pkg::CFG_DIV_HI:aipmc_pkg::CFG_DIV_LO]))
      aipmc_pkg::AIPMC_DIV_BY2: divLast = aipmc_pkg::DIV_LAST_BY2; // see R07
      aipmc_pkg::AIPMC_DIV_BY3: divLast = aipmc_pkg::DIV_LAST_BY3; // see R07
      default: divLast = aipmc_pkg::DIV_LAST_BY1; // see R07
    endcase
  end

  // two-entry buffer handshakes; the output side is paced by the sampling clock
  always_comb begin
    modInReady = q.bufCount != 2'h2;
    bufPush = modInValid && modInReady;
    bufHead = q.bufMem[q.bufRdPtr];
    bufPop = 1'b0;
    if (modEn && q.imclkEn && q.bufCount != 2'h0) begin
      bufPop = q.modState != aipmc_pkg::AIPMC_MOD_LEFT;
    end
  end

  // next state of the whole block
  always_comb begin
    d = q;
    // straps come from pins: two flops before use
    d.strapMeta = {strapFormat, strapRatio, strapRole, strapControlEnable};
    d.strapSync = q.strapMeta;

    // register writes; peak addresses ignore writes
    if (regWr) begin
      if (regAddr == aipmc_pkg::ADDR_AICFG) begin
        d.cfg = regWrData[7:0]; // see R01 // see R03 // see R05
      end else if (regAddr == aipmc_pkg::ADDR_CTRL2) begin
        d.ctrl2 = regWrData[7:0] & aipmc_pkg::CTRL2_WMASK;
      end
    end

    // register readback, answered one cycle after the read strobe
    d.rdValid = regRd;
    if (regRd) begin
      if (regAddr == aipmc_pkg::ADDR_PEAK_L) begin
        d.rdData = {regAddr, aipmc_pkg::PEAK_TAG, 4'h0, q.peakL}; // see R08 // see R10 // see R12
      end else if (regAddr == aipmc_pkg::ADDR_PEAK_R) begin
        d.rdData = {regAddr, aipmc_pkg::PEAK_TAG, 4'h0, q.peakR}; // see R09 // see R10
      end else if (regAddr == aipmc_pkg::ADDR_AICFG) begin
        d.rdData = {regAddr, aipmc_pkg::CFG_TAG, 2'h0, q.cfg};
      end else if (regAddr == aipmc_pkg::ADDR_CTRL2) begin
        d.rdData = {regAddr, aipmc_pkg::CFG_TAG, 2'h0, q.ctrl2};
      end else begin
        d.rdData = {regAddr, 12'h000};
      end
    end

    // peak trackers; a read only clears the channel it addresses
    {d.freshL, d.peakL} = peakNext(q.peakL, q.freshL,
      regRd && regAddr == aipmc_pkg::ADDR_PEAK_L, convValid && peakEn, convLeftCode);
    {d.freshR, d.peakR} = peakNext(q.peakR, q.freshR,
      regRd && regAddr == aipmc_pkg::ADDR_PEAK_R, convValid && peakEn, convRightCode);

    // internal master clock as a one-cycle enable
    if (q.divCnt >= divLast) begin // see R06 // see R07
      d.divCnt = 2'h0;
      d.imclkEn = 1'b1;
    end else begin
      d.divCnt = q.divCnt + 2'h1;
      d.imclkEn = 1'b0;
    end

    // buffer storage
    if (bufPush) begin
      d.bufMem[q.bufWrPtr] = modInData;
      d.bufWrPtr = !q.bufWrPtr;
    end
    if (bufPop) begin
      d.bufRdPtr = !q.bufRdPtr;
    end
    d.bufCount = q.bufCount + {1'b0, bufPush} - {1'b0, bufPop};

    // sampling clock is half the internal clock: 128 times the sample rate
    case (q.modState)
      aipmc_pkg::AIPMC_MOD_IDLE: begin
        if (modEn && q.imclkEn) begin // see R20
          d.modState = aipmc_pkg::AIPMC_MOD_LEFT;
          d.modPair = bufPop ? bufHead : '0;
          d.modData = bufPop ? bufHead[MOD_BITS-1:0] : '0; // see R21
        end
      end
      aipmc_pkg::AIPMC_MOD_LEFT: begin
        if (!modEn) begin
          d.modState = aipmc_pkg::AIPMC_MOD_IDLE;
          d.modData = '0;
        end else if (q.imclkEn) begin
          d.modState = aipmc_pkg::AIPMC_MOD_RIGHT;
          d.modData = q.modPair[2*MOD_BITS-1:MOD_BITS]; // see R21
        end
      end
      aipmc_pkg::AIPMC_MOD_RIGHT: begin
        if (!modEn) begin
          d.modState = aipmc_pkg::AIPMC_MOD_IDLE;
          d.modData = '0;
        end else if (q.imclkEn) begin
          // an empty buffer sends silence rather than repeating a stale pair
          d.modState = aipmc_pkg::AIPMC_MOD_LEFT;
          d.modPair = bufPop ? bufHead : '0;
          d.modData = bufPop ? bufHead[MOD_BITS-1:0] : '0; // see R21
        end
      end
      default: begin
        d.modState = aipmc_pkg::AIPMC_MOD_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge mclk) begin
    if (rst) begin
      q.strapMeta <= aipmc_pkg::STRAP_RESET;
      q.strapSync <= aipmc_pkg::STRAP_RESET;
      q.cfg <= aipmc_pkg::CFG_RESET; // see R02
      q.ctrl2 <= aipmc_pkg::CTRL2_RESET; // see R23
      q.divCnt <= 2'h0;
      q.imclkEn <= 1'b0;
      q.peakL <= aipmc_pkg::PEAK_RESET;
      q.peakR <= aipmc_pkg::PEAK_RESET;
      q.freshL <= 1'b1;
      q.freshR <= 1'b1;
      q.rdValid <= 1'b0;
      q.rdData <= 16'h0000;
      q.modState <= aipmc_pkg::AIPMC_MOD_IDLE;
      q.modPair <= '0;
      q.modData <= '0;
      q.bufMem <= '0;
      q.bufWrPtr <= 1'b0;
      q.bufRdPtr <= 1'b0;
      q.bufCount <= 2'h0;
    end else begin
      q <= d;
    end
  end

  // outputs; analog steering decodes from the effective configuration, which strap mode forces to reset values
  always_comb begin
    imclkEnable = q.imclkEn;
    rdValid = q.rdValid;
    rdData = q.rdData;
    leftBufferPowerDown = cfgEff[aipmc_pkg::CFG_LEFT_BUF_OFF]; // see R01
    rightBufferPowerDown = cfgEff[aipmc_pkg::CFG_RIGHT_BUF_OFF]; // see R01
    leftSingleEnded = cfgEff[aipmc_pkg::CFG_LEFT_SE]; // see R05
    rightSingleEnded = cfgEff[aipmc_pkg::CFG_RIGHT_SE]; // see R05
    leftSelectNeg = leftSingleEnded && cfgEff[aipmc_pkg::CFG_LEFT_SEL]; // see R03 // see R04
    rightSelectNeg = rightSingleEnded && cfgEff[aipmc_pkg::CFG_RIGHT_SEL]; // see R03 // see R04
    frameClocksDrive = extCtl ? !q.strapSync[aipmc_pkg::STRAP_ROLE]
                              : !q.ctrl2[aipmc_pkg::CTRL2_ROLE]; // see R16 // see R23
    dataFormat = extCtl ? q.strapSync[aipmc_pkg::STRAP_FMT_HI:aipmc_pkg::STRAP_FMT_LO]
                        : q.ctrl2[aipmc_pkg::CTRL2_FMT_HI:aipmc_pkg::CTRL2_FMT_LO]; // see R18 // see R22
    mclkRatio512 = extCtl ? q.strapSync[aipmc_pkg::STRAP_RATIO] : ctrlRatio512; // see R17
    modPinsDrive = q.modState != aipmc_pkg::AIPMC_MOD_IDLE; // see R20
    modulatorSampleClock = q.modState == aipmc_pkg::AIPMC_MOD_RIGHT; // see R21
    modData = q.modData;
  end

  buf_power_a: assert property (@(posedge mclk) disable iff (rst) // see R01
    regWr && regAddr == aipmc_pkg::ADDR_AICFG && regWrData[aipmc_pkg::CFG_LEFT_BUF_OFF]
      && !extCtl |=> extCtl || leftBufferPowerDown)
    else $error("left buffer not powered down after write");

  reset_default_a: assert property (@(posedge mclk) // see R02
    $past(rst) && !rst |-> !leftBufferPowerDown && !rightBufferPowerDown && frameClocksDrive)
    else $error("reset defaults wrong");

  select_gate_a: assert property (@(posedge mclk) disable iff (rst) // see R04
    !leftSingleEnded |-> !leftSelectNeg)
    else $error("left select active while differential");

  select_map_a: assert property (@(posedge mclk) disable iff (rst) // see R03
    regWr && regAddr == aipmc_pkg::ADDR_AICFG && regWrData[aipmc_pkg::CFG_LEFT_SE]
      && regWrData[aipmc_pkg::CFG_LEFT_SEL] && !extCtl
      |=> extCtl || leftSelectNeg)
    else $error("left negative input not selected");

  div_three_a: assert property (@(posedge mclk) disable iff (rst) // see R07
    imclkEnable && divLast == aipmc_pkg::DIV_LAST_BY3 ##1 divLast == aipmc_pkg::DIV_LAST_BY3
      |-> !imclkEnable ##1 !imclkEnable)
    else $error("divide by three pulses too often");

  peak_clear_a: assert property (@(posedge mclk) disable iff (rst) // see R14
    regRd && regAddr == aipmc_pkg::ADDR_PEAK_L && !convValid |=> q.peakL == 6'h00 && q.freshL)
    else $error("left peak not cleared by read");

  peak_hold_a: assert property (@(posedge mclk) disable iff (rst) // see R24
    convValid && peakEn && !q.freshR && !regRd && convRightCode >= q.peakR |=> $stable(q.peakR))
    else $error("right peak replaced by lower level");

  readback_fmt_a: assert property (@(posedge mclk) disable iff (rst) // see R10
    regRd && regAddr == aipmc_pkg::ADDR_PEAK_R ##1 rdValid |-> rdData[9:6] == 4'h0
      && rdData[11:10] == aipmc_pkg::PEAK_TAG)
    else $error("peak readback layout wrong");

  strap_role_a: assert property (@(posedge mclk) disable iff (rst) // see R16
    extCtl && q.strapSync[aipmc_pkg::STRAP_ROLE] |-> !frameClocksDrive)
    else $error("frame clocks driven in strapped slave role");

  mod_phase_a: assert property (@(posedge mclk) disable iff (rst) // see R21
    modEn && imclkEnable && modulatorSampleClock |=> !modulatorSampleClock && modPinsDrive)
    else $error("sampling clock failed to fall");

endmodule : aipmc_ctrl
`default_nettype wire

// ---- verif/aipmc_mod_sink.sv ----
`timescale 1ns/1ps
`default_nettype none
// far-side receiver of the raw modulator pins
module aipmc_mod_sink #(
  parameter int MB = 4
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic modPinsDrive,
  input wire logic modulatorSampleClock,
  input wire logic [MB-1:0] modData,
  output logic [2*MB-1:0] lastPair,
  output logic [7:0] pairCnt
);
  logic [MB-1:0] leftSample_q;
  logic haveLeft_q;
  // sample mid-phase on the falling edge, where the pins have settled
  always @(negedge mclk) begin
    if (rst || !modPinsDrive) begin
      haveLeft_q <= 1'b0;
      if (rst) begin
        pairCnt <= 8'h00;
        lastPair <= '0;
      end
    end else if (!modulatorSampleClock) begin
      leftSample_q <= modData;
      haveLeft_q <= 1'b1;
    end else if (haveLeft_q) begin
      lastPair <= {modData, leftSample_q};
      pairCnt <= pairCnt + 8'h01;
      haveLeft_q <= 1'b0; // a right half without its left is dropped
    end
  end
endmodule : aipmc_mod_sink
`default_nettype wire

// ---- verif/aipmc_ctrl_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module aipmc_ctrl_tb;
  logic mclk = 1'h0;
  logic rst = 1'h1;
  logic regWr = 1'h0;
  logic regRd = 1'h0;
  logic [3:0] regAddr = 4'h0;
  logic [9:0] regWrData = 10'h000;
  logic peakTrackEnable = 1'h0;
  logic ctrlRatio512 = 1'h0;
  logic convValid = 1'h0;
  logic [5:0] convLeftCode = 6'h00;
  logic [5:0] convRightCode = 6'h00;
  logic strapControlEnable = 1'h0;
  logic strapRole = 1'h0;
  logic strapRatio = 1'h0;
  logic [1:0] strapFormat = 2'h0;
  logic modInValid = 1'h0;
  logic [7:0] modInData = 8'h00;
  logic rdValid, modInReady, imclkEnable, leftBufferPowerDown, rightBufferPowerDown;
  logic leftSingleEnded, rightSingleEnded, leftSelectNeg, rightSelectNeg;
  logic frameClocksDrive, mclkRatio512, modPinsDrive, modulatorSampleClock;
  logic [1:0] dataFormat;
  logic [15:0] rdData;
  logic [3:0] modData;
  logic [7:0] lastPair, pairCnt;
  int errTotal = 0;
  int checks = 0;
  wire logic [7:0] cfgOut = {2'h0, leftBufferPowerDown, rightBufferPowerDown,
    leftSingleEnded, rightSingleEnded, leftSelectNeg, rightSelectNeg};
  wire logic [7:0] modeOut = {4'h0, frameClocksDrive, mclkRatio512, dataFormat};
  logic [7:0] cfgTab [5] = '{8'h3F, 8'h0F, 8'h35, 8'h2A, 8'h00};
  logic [7:0] divCnt [4] = '{8'h0C, 8'h06, 8'h04, 8'h0C};

  aipmc_ctrl #(.MOD_BITS(4)) i_dut (.mclk(mclk), .rst(rst), .regWr(regWr), .regRd(regRd),
    .regAddr(regAddr), .regWrData(regWrData), .rdValid(rdValid), .rdData(rdData),
    .peakTrackEnable(peakTrackEnable), .ctrlRatio512(ctrlRatio512), .convValid(convValid),
    .convLeftCode(convLeftCode), .convRightCode(convRightCode),
    .strapControlEnable(strapControlEnable), .strapRole(strapRole), .strapRatio(strapRatio),
    .strapFormat(strapFormat), .modInValid(modInValid), .modInReady(modInReady),
    .modInData(modInData), .imclkEnable(imclkEnable),
    .leftBufferPowerDown(leftBufferPowerDown), .rightBufferPowerDown(rightBufferPowerDown),
    .leftSingleEnded(leftSingleEnded), .rightSingleEnded(rightSingleEnded),
    .leftSelectNeg(leftSelectNeg), .rightSelectNeg(rightSelectNeg),
    .frameClocksDrive(frameClocksDrive), .dataFormat(dataFormat),
    .mclkRatio512(mclkRatio512), .modPinsDrive(modPinsDrive),
    .modulatorSampleClock(modulatorSampleClock), .modData(modData));

  aipmc_mod_sink #(.MB(4)) i_sink (.mclk(mclk), .rst(rst), .modPinsDrive(modPinsDrive),
    .modulatorSampleClock(modulatorSampleClock), .modData(modData),
    .lastPair(lastPair), .pairCnt(pairCnt));

  // 10 MHz master clock
  always #50 mclk = ~mclk;

  task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      errTotal++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp_word

  task automatic cmp_flags(input logic [7:0] got, input logic [7:0] exp);
    cmp_word({8'h00, got}, {8'h00, exp});
  endtask : cmp_flags

  // one-cycle strobe, then a cycle for the decoded outputs to land
  task automatic reg_write(input logic [3:0] a, input logic [9:0] d);
    @(negedge mclk);
    regWr = 1'h1;
    regAddr = a;
    regWrData = d;
    @(negedge mclk);
    regWr = 1'h0;
    @(negedge mclk);
  endtask : reg_write

  task automatic reg_read(input logic [3:0] a, input logic [15:0] exp);
    int n;
    @(negedge mclk);
    regRd = 1'h1;
    regAddr = a;
    @(negedge mclk);
    regRd = 1'h0;
    n = 0;
    while (rdValid !== 1'h1 && n < 4) begin
      @(negedge mclk);
      n++;
    end
    if (rdValid !== 1'h1) begin
      errTotal++; // a missing answer counts as a mismatch
    end
    cmp_word(rdData, exp);
  endtask : reg_read

  task automatic conv(input logic [5:0] l, input logic [5:0] r);
    @(negedge mclk);
    convValid = 1'h1;
    convLeftCode = l;
    convRightCode = r;
    @(negedge mclk);
    convValid = 1'h0;
  endtask : conv

  // request held until a rising edge sees ready high
  task automatic push(input logic [7:0] w);
    int n;
    @(negedge mclk);
    modInValid = 1'h1;
    modInData = w;
    n = 0;
    while (modInReady !== 1'h1 && n < 20) begin
      @(negedge mclk);
      n++;
    end
    if (modInReady !== 1'h1) begin
      errTotal++;
    end
    @(negedge mclk);
    modInValid = 1'h0;
  endtask : push

  task automatic wait_pair(input logic [7:0] k);
    int n;
    n = 0;
    while (pairCnt < k && n < 60) begin
      @(negedge mclk);
      n++;
    end
    if (pairCnt < k) begin
      errTotal++;
    end
  endtask : wait_pair

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks, errTotal);
    if (errTotal == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : complete_run

  // watchdog far beyond the few hundred cycles the tests need
  initial begin
    repeat (5000) @(posedge mclk);
    errTotal++;
    complete_run();
  end

  // main sequence
  initial begin
    logic [7:0] pulses;
    repeat (10) @(negedge mclk);
    rst = 1'h0;
    @(negedge mclk);
    cmp_flags(cfgOut, 8'h00);
    cmp_flags(modeOut, 8'h08);
    $display("test reset done");
    for (int f = 0; f < 4; f++) begin
      reg_write(4'h1, {3'h0, f[1:0], 5'h04});
      cmp_flags(modeOut, {6'h00, f[1:0]});
    end
    reg_read(4'h1, 16'h1064);
    $display("test format done");
    for (int i = 0; i < 5; i++) begin
      reg_write(4'h2, {2'h0, cfgTab[i]});
      cmp_flags(cfgOut, {2'h0, cfgTab[i][3], cfgTab[i][1], cfgTab[i][5], cfgTab[i][4],
        cfgTab[i][2] & cfgTab[i][5], cfgTab[i][0] & cfgTab[i][4]});
      reg_read(4'h2, {8'h20, cfgTab[i]});
    end
    $display("test config done");
    for (int d = 0; d < 4; d++) begin
      reg_write(4'h2, {2'h0, d[1:0], 6'h00});
      pulses = 8'h00;
      repeat (12) begin
        @(negedge mclk);
        pulses = pulses + {7'h00, imclkEnable === 1'h1};
      end
      cmp_flags(pulses, divCnt[d]);
    end
    $display("test divider done");
    reg_write(4'h2, 10'h000);
    peakTrackEnable = 1'h1;
    conv(6'h0A, 6'h14);
    conv(6'h0C, 6'h05);
    conv(6'h0B, 6'h09);
    reg_read(4'h3, 16'h380A);
    reg_read(4'h4, 16'h4805);
    reg_read(4'h3, 16'h3800);
    conv(6'h3F, 6'h3F);
    reg_read(4'h3, 16'h383F);
    reg_read(4'h4, 16'h483F);
    peakTrackEnable = 1'h0;
    conv(6'h07, 6'h07);
    reg_read(4'h3, 16'h3800);
    reg_write(4'h4, 10'h3FF);
    reg_read(4'h4, 16'h4800);
    reg_read(4'h9, 16'h9000);
    $display("test peak done");
    reg_write(4'h2, 10'h03F);
    strapControlEnable = 1'h1;
    strapRole = 1'h1;
    strapRatio = 1'h1;
    strapFormat = 2'h2;
    repeat (4) @(negedge mclk);
    cmp_flags(modeOut, 8'h06);
    cmp_flags(cfgOut, 8'h00);
    strapRole = 1'h0;
    strapRatio = 1'h0;
    strapFormat = 2'h1;
    repeat (4) @(negedge mclk);
    cmp_flags(modeOut, 8'h09);
    strapControlEnable = 1'h0;
    ctrlRatio512 = 1'h1;
    repeat (4) @(negedge mclk);
    cmp_flags(modeOut, 8'h07);
    cmp_flags(cfgOut, 8'h3F);
    $display("test strap done");
    reg_write(4'h2, 10'h000);
    push(8'hA5);
    push(8'hC3);
    cmp_flags({7'h00, modInReady}, 8'h00);
    reg_write(4'h1, 10'h080);
    wait_pair(8'h01);
    cmp_flags({7'h00, modPinsDrive}, 8'h01);
    cmp_flags(lastPair, 8'hA5);
    wait_pair(8'h02);
    cmp_flags(lastPair, 8'hC3);
    wait_pair(8'h03);
    cmp_flags(lastPair, 8'h00);
    $display("test modulator done");
    complete_run();
  end
endmodule : aipmc_ctrl_tb
`default_nettype wire
